// ### hw/nvs_pkg.sv
// Package: pins, commands, sequence addresses and timing for the nonvolatile SRAM host controller
package nvs_pkg;

  // ------------------------------------------------------------
  // Bus widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int MATCH_HI = 14;
  localparam int MATCH_LO = 2;
  localparam int MATCH_W = MATCH_HI - MATCH_LO + 1;

  // ------------------------------------------------------------
  // Sequence addresses
  // ------------------------------------------------------------
  localparam logic [15:0] SEQ_A1 = 16'h4E38;
  localparam logic [15:0] SEQ_A2 = 16'hB1C7;
  localparam logic [15:0] SEQ_A3 = 16'h83E0;
  localparam logic [15:0] SEQ_A4 = 16'h7C1F;
  localparam logic [15:0] SEQ_A5 = 16'h703F;
  localparam logic [15:0] SEQ_STORE = 16'h8FC0;
  localparam logic [15:0] SEQ_RECALL = 16'h4C63;
  localparam logic [15:0] SEQ_AS_OFF = 16'h8B45;
  localparam logic [15:0] SEQ_AS_ON = 16'h4B46;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int RD_ACCESS_NS = 60;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_RECOVER_NS = 20;
  localparam int RD_RECOVER_CYC = (RD_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int STORE_MS = 8;
  localparam int STORE_CYC = STORE_MS * 1000000 / CLK_NS;
  localparam int RECALL_US = 200;
  localparam int RECALL_CYC = RECALL_US * 1000 / CLK_NS;
  localparam int BUSY_WAIT_US = 30;
  localparam int BUSY_WAIT_CYC = BUSY_WAIT_US * 1000 / CLK_NS;

  // ------------------------------------------------------------
  // Commands and carriers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ   = 3'h0,
    CMD_WRITE  = 3'h1,
    CMD_STORE  = 3'h2,
    CMD_RECALL = 3'h3,
    CMD_AS_OFF = 3'h4,
    CMD_AS_ON  = 3'h5
  } nvs_cmd_t;

  typedef struct packed {
    nvs_cmd_t                  cmd;
    logic [ADDR_W-1:0]         addr;
    logic [DATA_W-1:0]         wdata;
    logic [1:0]                byte_en;
  } nvs_req_t;

  typedef struct packed {
    logic                      ce_n;
    logic                      oe_n;
    logic                      we_n;
    logic                      upper_byte_enable_n;
    logic                      lower_byte_enable_n;
    logic [ADDR_W-1:0]         addr;
  } nvs_pins_t;

endpackage : nvs_pkg

// ### hw/nvs_sync.sv
// Two-flop synchroniser for one pin
`timescale 1ns/10ps
module nvs_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      pin_out
);
  logic meta_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_q  <= 1'b1;
      pin_out <= 1'b1;
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule : nvs_sync

// ### hw/nvs_host.sv
// Host controller driving a nonvolatile SRAM: plain access and store/recall sequences
//
// Operation
// - Store needs six reads in exact order
// - Sequence reads keep write enable high
// - Recall uses prefix then read 0x4C63
// - Prefix then 0x8B45 disables automatic store
// - Prefix then 0x4B46 enables automatic store
// - Follow setting change with a store (host only raises store_pending; the store itself is left to the requester)
`timescale 1ns/10ps
module nvs_host #(
  parameter int STORE_CYC     = nvs_pkg::STORE_CYC,
  parameter int RECALL_CYC    = nvs_pkg::RECALL_CYC,
  parameter int BUSY_WAIT_CYC = nvs_pkg::BUSY_WAIT_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  input  wire logic                        req_valid,
  input  nvs_pkg::nvs_req_t                req,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [nvs_pkg::DATA_W-1:0]       rsp_rdata,
  output logic                             store_pending,
  output nvs_pkg::nvs_pins_t               pins,
  input  wire logic [nvs_pkg::DATA_W-1:0]  dq_in,
  output logic [nvs_pkg::DATA_W-1:0]       dq_out,
  output logic                             dq_oe,
  input  wire logic                        store_busy_n_in,
  output logic                             store_busy_n_out,
  output logic                             store_busy_n_oe
);

  // ------------------------------------------------------------
  // Types and counters
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_BOOT  = 7'b000_0001,
    ST_IDLE  = 7'b000_0010,
    ST_ACC   = 7'b000_0100,
    ST_GAP   = 7'b000_1000,
    ST_XFER  = 7'b001_0000,
    ST_WBUSY = 7'b010_0000,
    ST_DONE  = 7'b100_0000
  } nvs_state_t;

  localparam int CNT_W = 32;
  localparam logic [2:0] LAST_STEP = 3'h5;

  nvs_state_t          state_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [2:0]          step_q;
  logic [15:0]         seq_last_q;
  logic                seq_mode_q;
  logic                is_write_q;
  logic                busy_sync;

  nvs_sync u_busy_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  (store_busy_n_in),
    .pin_out (busy_sync)
  );

  function automatic logic [15:0] seq_addr(input logic [2:0] s, input logic [15:0] last);
    case (s)
      3'h0:    seq_addr = nvs_pkg::SEQ_A1;
      3'h1:    seq_addr = nvs_pkg::SEQ_A2;
      3'h2:    seq_addr = nvs_pkg::SEQ_A3;
      3'h3:    seq_addr = nvs_pkg::SEQ_A4;
      3'h4:    seq_addr = nvs_pkg::SEQ_A5;
      default: seq_addr = last;
    endcase
  endfunction : seq_addr

  function automatic logic [15:0] last_addr(input nvs_pkg::nvs_cmd_t c);
    case (c)
      nvs_pkg::CMD_RECALL: last_addr = nvs_pkg::SEQ_RECALL;
      nvs_pkg::CMD_AS_OFF: last_addr = nvs_pkg::SEQ_AS_OFF;
      nvs_pkg::CMD_AS_ON:  last_addr = nvs_pkg::SEQ_AS_ON;
      default:             last_addr = nvs_pkg::SEQ_STORE;
    endcase
  endfunction : last_addr

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q    <= ST_BOOT;
      cnt_q      <= '0;
      step_q     <= 3'h0;
      seq_last_q <= nvs_pkg::SEQ_STORE;
      seq_mode_q <= 1'b0;
      is_write_q <= 1'b0;
      req_ready  <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_rdata  <= '0;
      pins       <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, upper_byte_enable_n: 1'b1,
                      lower_byte_enable_n: 1'b1, addr: '0};
      dq_out     <= '0;
      dq_oe      <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_BOOT: begin
          // Wait out power-up recall; no access while busy low
          if (!busy_sync) begin
            cnt_q <= '0;
          end else if (cnt_q >= CNT_W'(RECALL_CYC)) begin
            state_q   <= ST_IDLE;
            req_ready <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_IDLE: begin
          if (req_valid && busy_sync) begin
            req_ready  <= 1'b0;
            cnt_q      <= '0;
            step_q     <= 3'h0;
            seq_last_q <= last_addr(req.cmd);
            seq_mode_q <= (req.cmd != nvs_pkg::CMD_READ) && (req.cmd != nvs_pkg::CMD_WRITE);
            is_write_q <= (req.cmd == nvs_pkg::CMD_WRITE);
            state_q    <= ST_ACC;
            pins.ce_n  <= 1'b0;
            if (req.cmd == nvs_pkg::CMD_WRITE) begin
              pins.addr <= req.addr;
              pins.we_n <= 1'b0;
              pins.upper_byte_enable_n <= ~req.byte_en[1];
              pins.lower_byte_enable_n <= ~req.byte_en[0];
              dq_out    <= req.wdata;
              dq_oe     <= 1'b1;
            end else if (req.cmd == nvs_pkg::CMD_READ) begin
              pins.addr <= req.addr;
              pins.oe_n <= 1'b0;
              pins.upper_byte_enable_n <= ~req.byte_en[1];
              pins.lower_byte_enable_n <= ~req.byte_en[0];
            end else begin
              // Sequence reads: only bits 14..2 matter, bit 16 driven zero
              pins.addr <= {1'b0, nvs_pkg::SEQ_A1};
              pins.oe_n <= 1'b0;
              pins.upper_byte_enable_n <= 1'b0;
              pins.lower_byte_enable_n <= 1'b0;
            end
          end
        end
        ST_ACC: begin
          if (cnt_q >= CNT_W'(nvs_pkg::RD_ACCESS_CYC - 1)) begin
            cnt_q     <= '0;
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            dq_oe     <= 1'b0;
            if (!is_write_q && !seq_mode_q) begin
              rsp_rdata <= dq_in;
            end
            state_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_GAP: begin
          if (cnt_q >= CNT_W'(nvs_pkg::RD_RECOVER_CYC - 1)) begin
            cnt_q <= '0;
            if (seq_mode_q && step_q != LAST_STEP) begin
              // Back-to-back reads, nothing else interleaved
              step_q    <= step_q + 3'h1;
              state_q   <= ST_ACC;
              pins.ce_n <= 1'b0;
              pins.oe_n <= 1'b0;
              pins.addr <= {1'b0, seq_addr(step_q + 3'h1, seq_last_q)};
            end else if (seq_mode_q && (seq_last_q == nvs_pkg::SEQ_STORE ||
                                        seq_last_q == nvs_pkg::SEQ_RECALL)) begin
              state_q <= ST_XFER;
            end else begin
              state_q <= ST_DONE;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_XFER: begin
          // Chip disabled for the whole transfer time
          if (cnt_q >= CNT_W'((seq_last_q == nvs_pkg::SEQ_STORE) ? STORE_CYC : RECALL_CYC)) begin
            cnt_q   <= '0;
            state_q <= ST_WBUSY;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ST_WBUSY: begin
          // Store keeps busy low until done; wait for release
          if (busy_sync) begin
            state_q <= ST_DONE;
          end else if (cnt_q < CNT_W'(BUSY_WAIT_CYC)) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          rsp_valid <= 1'b1;
          req_ready <= 1'b1;
          state_q   <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Store reminder and busy pin
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      store_pending <= 1'b0;
    end else if (state_q == ST_XFER && seq_last_q == nvs_pkg::SEQ_STORE) begin
      store_pending <= 1'b0;
    end else if (state_q == ST_DONE && seq_mode_q &&
                 (seq_last_q == nvs_pkg::SEQ_AS_OFF || seq_last_q == nvs_pkg::SEQ_AS_ON)) begin
      store_pending <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      store_busy_n_out <= 1'b0;
      store_busy_n_oe  <= 1'b0;
    end else begin
      store_busy_n_out <= 1'b0;
      store_busy_n_oe  <= 1'b0;
    end
  end

endmodule : nvs_host

// ### dv/nvs_host_checker.sv
// Port assertions for the nonvolatile SRAM host controller
`timescale 1ns/10ps
module nvs_host_checker (
  input wire logic         clk_sys,
  input wire logic         reset,
  input wire logic         req_valid,
  input nvs_pkg::nvs_req_t req,
  input wire logic         req_ready,
  input wire logic         rsp_valid,
  input nvs_pkg::nvs_pins_t pins,
  input wire logic         dq_oe,
  input wire logic         store_busy_n_in,
  input wire logic         store_busy_n_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_busy_not_pulled: assert property (!store_busy_n_oe)
    else $error("host pulled busy pin");
  a_busy_blocks_chip: assert property (!store_busy_n_in [*3] |-> pins.ce_n)
    else $error("chip selected while busy");
  a_read_we_high: assert property (!pins.oe_n |-> pins.we_n)
    else $error("write enable low during read");
  a_no_contention: assert property (dq_oe |-> pins.oe_n)
    else $error("data driven during read");
  a_access_width: assert property ($fell(pins.ce_n) |-> !pins.ce_n [*3] ##1 pins.ce_n)
    else $error("access window not three cycles");
  a_take_drops_ready: assert property (req_valid && req_ready && $past(store_busy_n_in)
    && $past(store_busy_n_in, 2) && $past(store_busy_n_in, 3) |=> !req_ready)
    else $error("ready stayed high after take");
  a_read_answer: assert property (req_valid && req_ready && req.cmd == nvs_pkg::CMD_READ
    && $past(store_busy_n_in, 2) && $past(store_busy_n_in, 3) |-> ##[4:6] rsp_valid)
    else $error("read answer late");
endmodule : nvs_host_checker

bind nvs_host nvs_host_checker u_chk (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .pins(pins), .dq_oe(dq_oe),
  .store_busy_n_in(store_busy_n_in), .store_busy_n_oe(store_busy_n_oe));

// ### dv/nvs_dev.sv
// Behavioural nonvolatile SRAM with store and recall sequences
`timescale 1ns/10ps
module nvs_dev #(
  parameter int REC_T = 30,
  parameter int STO_T = 25
) (
  input wire logic          clk_sys,
  input nvs_pkg::nvs_pins_t pins,
  input wire logic [15:0]   dq_out,
  output logic [15:0]       dq_in,
  output logic              busy_pull
);
  logic [15:0] mem [256];
  logic [15:0] nv [256];
  logic [15:0] seq [5] = '{nvs_pkg::SEQ_A1, nvs_pkg::SEQ_A2, nvs_pkg::SEQ_A3,
                           nvs_pkg::SEQ_A4, nvs_pkg::SEQ_A5};
  logic [15:0] last_q = 16'h0000;
  logic        ce_q = 1'b1;
  logic        rd_q = 1'b0;
  logic        as_en = 1'b1;
  logic        written = 1'b0;
  int          busy_cnt = REC_T;
  int          step = 0;
  int          n_store = 0;
  int          n_recall = 0;
  wire         rd = !pins.ce_n && !pins.oe_n && pins.we_n && busy_cnt == 0;
  assign dq_in = rd ? mem[pins.addr[7:0]] : ~last_q;
  assign busy_pull = busy_cnt != 0;

  function automatic logic hit(input logic [15:0] a);
    return pins.addr[14:2] == a[14:2];
  endfunction : hit

  initial begin
    for (int i = 0; i < 256; i++) begin
      nv[i] = 16'h0000;
      mem[i] = nv[i];
    end
  end

  always @(posedge clk_sys) begin
    last_q <= dq_in;
    ce_q <= pins.ce_n;
    if (!pins.ce_n) rd_q <= rd;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (!pins.ce_n && !pins.we_n && busy_cnt == 0) begin
      mem[pins.addr[7:0]] <= dq_out;
      written <= 1'b1;
    end
    if (pins.ce_n && !ce_q) begin
      if (!rd_q) step <= 0;
      else if (step == 5) begin
        step <= hit(nvs_pkg::SEQ_A1) ? 1 : 0;
        if (hit(nvs_pkg::SEQ_STORE)) begin
          for (int i = 0; i < 256; i++) nv[i] <= mem[i];
          n_store <= n_store + 1;
          busy_cnt <= STO_T;
          written <= 1'b0;
        end
        if (hit(nvs_pkg::SEQ_RECALL)) begin
          for (int i = 0; i < 256; i++) mem[i] <= nv[i];
          n_recall <= n_recall + 1;
          busy_cnt <= REC_T;
          written <= 1'b0;
        end
        if (hit(nvs_pkg::SEQ_AS_OFF)) as_en <= 1'b0;
        if (hit(nvs_pkg::SEQ_AS_ON)) as_en <= 1'b1;
      end
      else if (hit(nvs_pkg::SEQ_A1)) step <= 1;
      else if (hit(seq[step])) step <= step + 1;
      else step <= 0;
    end
  end
endmodule : nvs_dev

// ### dv/tb_top.sv
// Self-checking testbench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
module tb_top;
  logic               clk_sys = 1'b0;
  logic               reset = 1'b1;
  logic               req_valid = 1'b0;
  nvs_pkg::nvs_req_t  req = '0;
  nvs_pkg::nvs_pins_t pins;
  logic               req_ready, rsp_valid, store_pending, dq_oe, b_out, b_oe, pull;
  logic [15:0]        rsp_rdata, dq_in, dq_out, rd;
  int                 n_fail = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  wire                busy_n = !(pull || (b_oe && !b_out));

  always #10 clk_sys = ~clk_sys;

  nvs_host #(.STORE_CYC(20), .RECALL_CYC(10), .BUSY_WAIT_CYC(5)) u_nvs_host (
    .clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .store_pending(store_pending), .pins(pins),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .store_busy_n_in(busy_n),
    .store_busy_n_out(b_out), .store_busy_n_oe(b_oe));
  nvs_dev u_nvs_dev (.clk_sys(clk_sys), .pins(pins), .dq_out(dq_out), .dq_in(dq_in),
    .busy_pull(pull));

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic cmd(input nvs_pkg::nvs_cmd_t c, input logic [16:0] a, input logic [15:0] d);
    int   n;
    logic rdy;
    @(negedge clk_sys);
    req = '{c, a, d, 2'b11};
    req_valid = 1'b1;
    n = 0;
    // Hold until an edge with ready high has dropped ready
    do begin
      rdy = req_ready;
      @(negedge clk_sys);
      n++;
    end while (!(rdy === 1'b1 && req_ready === 1'b0) && n < 5000);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    rd = rsp_rdata;
    chk(rsp_valid === 1'b1, "no response");
  endtask : cmd

  task automatic t_boot;
    int n;
    chk(req_ready === 1'b0, "ready during recall");
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk(req_ready === 1'b1 && busy_n === 1'b1 && n > 18, "ready timing");
  endtask : t_boot

  task automatic t_store_recall;
    cmd(nvs_pkg::CMD_WRITE, 17'h0_0010, 16'h1234);
    cmd(nvs_pkg::CMD_READ, 17'h0_0010, 16'h0000);
    chk(rd === 16'h1234, "read back");
    cmd(nvs_pkg::CMD_WRITE, 17'h0_0020, 16'hA5A5);
    cmd(nvs_pkg::CMD_STORE, 17'h0_0000, 16'h0000);
    chk(u_nvs_dev.n_store == 1 && u_nvs_dev.nv[32] === 16'hA5A5, "store");
    cmd(nvs_pkg::CMD_WRITE, 17'h0_0020, 16'h5A5A);
    cmd(nvs_pkg::CMD_RECALL, 17'h0_0000, 16'h0000);
    cmd(nvs_pkg::CMD_READ, 17'h0_0020, 16'h0000);
    chk(rd === 16'hA5A5 && u_nvs_dev.n_recall == 1, "recall");
  endtask : t_store_recall

  task automatic t_autostore;
    chk(u_nvs_dev.as_en === 1'b1, "autostore default");
    cmd(nvs_pkg::CMD_AS_OFF, 17'h0_0000, 16'h0000);
    chk(u_nvs_dev.as_en === 1'b0 && store_pending === 1'b1, "autostore off");
    cmd(nvs_pkg::CMD_AS_ON, 17'h0_0000, 16'h0000);
    chk(u_nvs_dev.as_en === 1'b1 && store_pending === 1'b1, "autostore on");
    chk(u_nvs_dev.written === 1'b0, "write latch set after recall");
    cmd(nvs_pkg::CMD_STORE, 17'h0_0000, 16'h0000);
    chk(u_nvs_dev.n_store == 2 && store_pending === 1'b0, "store after change");
    chk(b_oe === 1'b0 && b_out === 1'b0, "host drove busy pin");
  endtask : t_autostore

  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    t_boot();
    t_store_recall();
    t_autostore();
    report_and_stop();
  end
endmodule : tb_top
